// ===== verilog/ltexec_core.sv
// Notes on behaviour
// - Load place jumps to the address in operand bits 14-0.
// - Load place sets permit when operand bit 21 is one, else clears it.
// - Load place sets trap mode if operand bit 19 is one; zero leaves it.
// - Load place clears the quasi flag at its last pulse.
// - Load place fetch sets remember at last pulse; execute state 4 follows.
// - Load place state 4 reads Z via B and adder; bits 14-0 to address field.
// - Load place state 4 clears permit, then sets it from adder bit 21.
// - Next fetch copies address field to program counter; remember clears.
// - Load Q reads Z into B in state 4, writes B to Q cell in state 5.
// - Load Q never writes location Z.
// - Load index copies Z into index cell selected by instruction bits 17-15.
// - Load index reads Z in state 2, writes index cell in state 4.
// - Restore loads overflow, permit, test from operand bits 22, 21, 20.
// - Restore places operand bits 14-0 into the program counter.
// - Restore sets trap mode when bit 19 is one, else leaves it.
// - Restore resets the quasi flag when in trapping mode.
// - Restore state 4 clears flags, then sets them from adder bits.
// - Restore sets remember at fetch end, clears it as the next fetch begins.
// - Next fetch after restore copies address field into program counter.
`timescale 1ns/1ps
`default_nettype none

module ltexec_core (
  input  wire logic                        clock,
  input  wire logic                        rst,
  input  wire logic                        start,
  input  wire logic [23:0]                 instr_word,
  input  wire logic [14:0]                 pc_in,
  input  wire ltexec_pkg::ltexec_flags_t   flags_in,
  input  wire logic                        mem_ready,
  input  wire logic [23:0]                 mem_rdata,
  output var  ltexec_pkg::ltexec_mem_req_t mem_out,
  output var  ltexec_pkg::ltexec_flags_t   flags_out,
  output logic [14:0]                      prog_counter,
  output logic [23:0]                      b_reg,
  output logic                             busy,
  output logic                             done,
  output logic                             no_interrupt,
  output logic                             illegal
);
  import ltexec_pkg::*;

  ltexec_regs_t  r;
  ltexec_regs_t  next_r;
  logic [23:0]   adder;
  logic [5:0]    opc;

  // Decoded view of the latched instruction
  logic          is_place;
  logic          is_restore;
  logic          is_load_q;
  logic          is_index;
  logic          is_transfer;
  logic [2:0]    xsel;
  logic [14:0]   z_addr;
  logic [14:0]   x_cell_addr;
  logic          mem_answer;

  // Flag images for the two transfer instructions
  ltexec_flags_t place_flags;
  ltexec_flags_t restore_flags;

  // =========================================================
  // Request builders for the core memory port
  function automatic ltexec_mem_req_t mem_read(
    input logic [14:0] addr
  );
    ltexec_mem_req_t q;
    q      = '0;
    q.req  = 1'b1;
    q.addr = addr;
    return q;
  endfunction

  function automatic ltexec_mem_req_t mem_write(
    input logic [14:0] addr,
    input logic [23:0] data
  );
    ltexec_mem_req_t q;
    q       = '0;
    q.req   = 1'b1;
    q.write = 1'b1;
    q.addr  = addr;
    q.wdata = data;
    return q;
  endfunction

  // Program counter wraps within the 15-bit core address space
  function automatic logic [14:0] pc_step(
    input logic [14:0] pc
  );
    return pc + 15'h0001;
  endfunction

  // =========================================================
  // Flag updates at the end of the execute state
  // Permit is cleared early and set late in the original sequence; both
  // land on one edge here, as nothing samples the flag in between
  function automatic ltexec_flags_t place_update(
    input ltexec_flags_t f,
    input logic [23:0]   sum
  );
    ltexec_flags_t u;
    u                       = f;
    u.interrupt_permit_flag = sum[BIT_PMT];
    if (sum[BIT_TRAP]) begin
      u.trap_mode_flag = 1'b1;
    end
    u.quasi_flag = 1'b0;
    return u;
  endfunction

  // Trap mode is judged before this word's own bit 19 lands, so a restore
  // that first enters trapping mode leaves quasi as it was
  function automatic ltexec_flags_t restore_update(
    input ltexec_flags_t f,
    input logic [23:0]   sum
  );
    ltexec_flags_t u;
    u                       = f;
    u.overflow_flag         = sum[BIT_OFL];
    u.interrupt_permit_flag = sum[BIT_PMT];
    u.test_flag             = sum[BIT_TST];
    if (sum[BIT_TRAP]) begin
      u.trap_mode_flag = 1'b1;
    end
    if (f.trap_mode_flag) begin
      u.quasi_flag = 1'b0;
    end
    return u;
  endfunction

  // =========================================================
  // Opcode decode
  // Taken from the latched word, so instr_word may move once start is taken
  assign opc         = r.instr[OPC_HI:OPC_LO];
  assign is_place    = (opc == OPC_LOAD_PLACE);
  assign is_restore  = (opc == OPC_LOAD_RESTORE);
  assign is_load_q   = (opc == OPC_LOAD_Q);
  assign is_index    = (opc == OPC_LOAD_INDEX);
  assign is_transfer = is_place || is_restore;
  assign xsel        = r.instr[XSEL_HI:XSEL_LO];
  assign z_addr      = r.addr_field;
  assign x_cell_addr = {12'h000, xsel};
  assign mem_answer  = r.mem.req && mem_ready;

  // mem_rdata feeds the adder straight through; no second operand for these loads
  assign adder         = mem_rdata;
  assign place_flags   = place_update(r.flags, adder);
  assign restore_flags = restore_update(r.flags, adder);

  // =========================================================
  // Sequencer
  // Sequence per instruction:
  //   idle -> fetch -> exec          place, restore
  //   idle -> fetch -> exec -> s5    load Q (read Z, write Q cell)
  //   idle -> fetch -> s2   -> exec  load index (read Z, write index cell)
  // Each access waits in its state until the core answers, so any
  // memory latency is absorbed without further handshaking
  always_comb begin
    next_r      = r;
    next_r.done = 1'b0;
    case (r.state)
      LTX_IDLE: begin
        // Requests while busy are simply not looked at
        if (start) begin
          next_r.instr        = instr_word;
          next_r.prog_counter = pc_in;
          next_r.flags        = flags_in;
          next_r.illegal      = 1'b0;
          if (r.pending_jump) begin
            // Fetch after a transfer: address field becomes the new counter
            next_r.prog_counter        = r.addr_field;
            next_r.flags.remember_flag = 1'b0;
            next_r.pending_jump        = 1'b0;
          end
          // Only the low 14 bits address Z; bit 14 is an addressing mode bit
          next_r.addr_field = {1'b0, instr_word[13:0]};
          next_r.state      = LTX_FETCH;
        end
      end
      LTX_FETCH: begin
        // Unknown opcodes finish here with the counter stepped on
        next_r.state = LTX_IDLE;
        next_r.done  = 1'b1;
        if (is_transfer) begin
          next_r.op                  = is_place ? LTX_OP_PLACE : LTX_OP_RESTORE;
          next_r.flags.remember_flag = 1'b1;
          next_r.state               = LTX_EXEC;
          next_r.done                = 1'b0;
        end else if (is_load_q) begin
          next_r.op    = LTX_OP_Q;
          next_r.state = LTX_EXEC;
          next_r.done  = 1'b0;
        end else if (is_index) begin
          next_r.op    = LTX_OP_INDEX;
          next_r.state = LTX_S2;
          next_r.done  = 1'b0;
          // Undefined encoding: flagged, but executed anyway
          next_r.illegal = (xsel == 3'h0);
        end else begin
          next_r.prog_counter = pc_step(r.prog_counter);
        end
        // One read request covers every known instruction: it fetches Z
        if (next_r.state != LTX_IDLE) begin
          next_r.mem = mem_read(z_addr);
        end
      end
      LTX_S2: begin
        // Z is in hand: turn the read straight into the index cell write
        if (mem_answer) begin
          next_r.b_reg = mem_rdata;
          next_r.mem   = mem_write(x_cell_addr, mem_rdata);
          next_r.state = LTX_EXEC;
        end
      end
      LTX_EXEC: begin
        if (mem_answer) begin
          // Memory has answered: for place, restore and load Q the word of Z stands on mem_rdata now
          next_r.mem = '0;
          case (r.op)
            LTX_OP_PLACE: begin
              next_r.b_reg      = mem_rdata;
              next_r.addr_field = adder[ADDR_HI:0];
              next_r.flags      = place_flags;
            end
            LTX_OP_RESTORE: begin
              next_r.b_reg      = mem_rdata;
              next_r.addr_field = adder[ADDR_HI:0];
              next_r.flags      = restore_flags;
            end
            LTX_OP_Q: begin
              next_r.b_reg = mem_rdata;
              // Location Z is only read; the copy goes to the fixed cell
              next_r.mem   = mem_write(Q_CELL_ADDR, mem_rdata);
            end
            default: begin
              // Load index: the index cell write has been acknowledged
              next_r.mem = '0;
            end
          endcase
          // Transfers leave the new counter for the next fetch to apply
          next_r.pending_jump = (r.op == LTX_OP_PLACE) || (r.op == LTX_OP_RESTORE);
          // Only load Q lets an interrupt in right behind it
          next_r.no_interrupt = (r.op != LTX_OP_Q);
          if (r.op == LTX_OP_Q) begin
            next_r.state = LTX_S5;
          end else begin
            next_r.state = LTX_IDLE;
            next_r.done  = 1'b1;
            if (r.op == LTX_OP_INDEX) begin
              next_r.prog_counter = pc_step(r.prog_counter);
            end
          end
        end
      end
      LTX_S5: begin
        // Q cell write acknowledged ends the instruction
        if (mem_answer) begin
          next_r.mem          = '0;
          next_r.prog_counter = pc_step(r.prog_counter);
          next_r.no_interrupt = 1'b0;
          next_r.state        = LTX_IDLE;
          next_r.done         = 1'b1;
        end
      end
      default: begin
        next_r.state = LTX_IDLE;
      end
    endcase
    // Busy is a flip-flop of its own so the port never glitches
    next_r.busy = (next_r.state != LTX_IDLE);
  end

  // =========================================================
  // State register
  // Reset clears every field, which also lands the sequencer in idle
  // No clock enable: every field moves on every edge
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // =========================================================
  // Outputs, each one a field of the state register
  assign mem_out      = r.mem;
  assign flags_out    = r.flags;
  assign prog_counter = r.prog_counter;
  assign b_reg        = r.b_reg;
  assign busy         = r.busy;
  assign done         = r.done;
  assign no_interrupt = r.no_interrupt;
  assign illegal      = r.illegal;

endmodule // ltexec_core

`default_nettype wire

// ===== common/ltexec_pkg.sv
package ltexec_pkg;

  localparam int WORD_W = 24;
  localparam int ADDR_W = 15;
  localparam int XSEL_W = 3;
  localparam int OPC_W  = 6;

  // Instruction field positions
  localparam int OPC_HI  = 23;
  localparam int OPC_LO  = 18;
  localparam int XSEL_HI = 17;
  localparam int XSEL_LO = 15;
  localparam int ADDR_HI = 14;

  // Operand bit positions
  localparam int BIT_OFL  = 22;
  localparam int BIT_PMT  = 21;
  localparam int BIT_TST  = 20;
  localparam int BIT_TRAP = 19;

  // Opcodes (octal 15, 10, 35 and load index)
  localparam logic [5:0] OPC_LOAD_PLACE   = 6'h0D;
  localparam logic [5:0] OPC_LOAD_Q       = 6'h08;
  localparam logic [5:0] OPC_LOAD_INDEX   = 6'h09;
  localparam logic [5:0] OPC_LOAD_RESTORE = 6'h1D;

  // Fixed core address of the Q cell (octal 10)
  localparam logic [14:0] Q_CELL_ADDR = 15'h0008;

  localparam logic [23:0] WORD_ZERO = 24'h000000;
  localparam logic [14:0] ADDR_ZERO = 15'h0000;

  typedef enum logic [2:0] {
    LTX_IDLE,
    LTX_FETCH,
    LTX_S2,
    LTX_EXEC,
    LTX_S5
  } ltexec_state_t;

  typedef enum logic [1:0] {
    LTX_OP_PLACE,
    LTX_OP_Q,
    LTX_OP_INDEX,
    LTX_OP_RESTORE
  } ltexec_op_t;

  // Core memory request toward the far side
  typedef struct packed {
    logic        req;
    logic        write;
    logic [14:0] addr;
    logic [23:0] wdata;
  } ltexec_mem_req_t;

  // Status flip-flops of the arithmetic unit
  typedef struct packed {
    logic interrupt_permit_flag;
    logic trap_mode_flag;
    logic quasi_flag;
    logic overflow_flag;
    logic test_flag;
    logic remember_flag;
  } ltexec_flags_t;

  typedef struct packed {
    ltexec_state_t   state;
    ltexec_op_t      op;
    logic [23:0]     instr;
    logic [23:0]     b_reg;
    logic [14:0]     addr_field;
    logic [14:0]     prog_counter;
    ltexec_mem_req_t mem;
    ltexec_flags_t   flags;
    logic            pending_jump;
    logic            no_interrupt;
    logic            done;
    logic            illegal;
    logic            busy;
  } ltexec_regs_t;

endpackage

// ===== verification/ltexec_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Core memory behind the block
module ltexec_mem_model (
  input  wire logic                        clock,
  input  wire logic [3:0]                  lat,
  input  wire ltexec_pkg::ltexec_mem_req_t mem_in,
  output logic                             ready = 1'b0,
  output logic [23:0]                      rdata = 24'h000000
);
  import ltexec_pkg::*;
  logic [23:0] mem [0:32767];
  int          wait_n = 0;
  always @(posedge clock) begin
    ready <= 1'b0;
    // Stale data flips so a late read cannot pass by luck
    rdata <= ~rdata;
    if (mem_in.req && !ready) begin
      wait_n <= wait_n + 1;
      if (wait_n >= lat) begin
        wait_n <= 0;
        ready  <= 1'b1;
        if (mem_in.write) mem[mem_in.addr] <= mem_in.wdata;
        else rdata <= mem[mem_in.addr];
      end
    end
  end
endmodule // ltexec_mem_model
`default_nettype wire

// ===== verification/ltexec_core_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Port checker
module ltexec_chk (
  input wire logic                        clock,
  input wire logic                        rst,
  input wire logic                        start,
  input wire logic [23:0]                 instr_word,
  input wire ltexec_pkg::ltexec_flags_t   flags_in,
  input wire logic                        mem_ready,
  input wire logic [23:0]                 mem_rdata,
  input wire ltexec_pkg::ltexec_mem_req_t mem_out,
  input wire ltexec_pkg::ltexec_flags_t   flags_out,
  input wire logic                        busy,
  input wire logic                        done,
  input wire logic                        no_interrupt
);
  import ltexec_pkg::*;
  logic [23:0] ins;
  logic [23:0] z;
  logic        trap0;
  wire logic [5:0] opc = ins[23:18];
  wire logic       plr = opc == OPC_LOAD_PLACE || opc == OPC_LOAD_RESTORE;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ins   <= WORD_ZERO;
      z     <= WORD_ZERO;
      trap0 <= 1'b0;
    end else begin
      if (start && !busy) ins <= instr_word;
      if (start && !busy) trap0 <= flags_in.trap_mode_flag;
      if (mem_ready && !mem_out.write) z <= mem_rdata;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_req_held: assert property (mem_out.req && !mem_ready |=> $stable(mem_out))
    else $error("request moved");
  a_read_at_z: assert property (mem_out.req && !mem_out.write |-> mem_out.addr == {1'b0, ins[13:0]})
    else $error("read address");
  a_q_cell_write: assert property (opc == OPC_LOAD_Q && mem_out.req && mem_out.write
    |-> mem_out.addr == Q_CELL_ADDR && mem_out.wdata == z) else $error("q cell write");
  a_index_write: assert property (opc == OPC_LOAD_INDEX && mem_out.req && mem_out.write
    |-> mem_out.addr == {12'h000, ins[17:15]} && mem_out.wdata == z) else $error("index write");
  a_permit_load: assert property (done && plr |-> flags_out.interrupt_permit_flag == z[21])
    else $error("permit");
  a_trap_sticky: assert property (done && plr |-> flags_out.trap_mode_flag == (z[19] | trap0))
    else $error("trap mode");
  a_quasi_remember: assert property (done && plr
    |-> (!flags_out.quasi_flag || (opc == OPC_LOAD_RESTORE && !trap0))
        && flags_out.remember_flag) else $error("quasi or remember");
  a_restore_flags: assert property (done && opc == OPC_LOAD_RESTORE
    |-> {flags_out.overflow_flag, flags_out.test_flag} == {z[22], z[20]}) else $error("restore");
  a_intr_inhibit: assert property (done && opc == OPC_LOAD_Q |-> !no_interrupt)
    else $error("inhibit");
endmodule // ltexec_chk
bind ltexec_core ltexec_chk u_chk (.clock, .rst, .start, .instr_word, .flags_in, .mem_ready,
  .mem_rdata, .mem_out, .flags_out, .busy, .done, .no_interrupt);
`default_nettype wire

// ===== verification/ltexec_core_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Bench
module ltexec_core_tb_top;
  import ltexec_pkg::*;
  logic            clock = 1'b0, rst = 1'b1, start = 1'b0, mem_ready, busy, done;
  logic            no_interrupt, illegal;
  logic [23:0]     instr_word = WORD_ZERO, mem_rdata, b_reg;
  logic [14:0]     pc_in = ADDR_ZERO, prog_counter, pc_seen;
  logic [3:0]      lat = 4'h0;
  ltexec_flags_t   flags_in = 6'h00, flags_out;
  ltexec_mem_req_t mem_out;
  int              err_total = 0, checks_done = 0, cycles = 0;
  always #2 clock = ~clock;
  ltexec_core uut (.clock, .rst, .start, .instr_word, .pc_in, .flags_in, .mem_ready, .mem_rdata,
    .mem_out, .flags_out, .prog_counter, .b_reg, .busy, .done, .no_interrupt, .illegal);
  ltexec_mem_model pm (.clock, .lat, .mem_in(mem_out), .ready(mem_ready), .rdata(mem_rdata));
  task automatic chk(string what, logic [23:0] exp, logic [23:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic run(logic [5:0] opc, logic [2:0] x, logic [14:0] z, logic [5:0] f);
    int n;
    @(posedge clock);
    instr_word <= {opc, x, z};
    flags_in   <= f;
    start      <= 1'b1;
    @(posedge clock);
    start <= 1'b0;
    repeat (2) @(negedge clock);
    pc_seen = prog_counter;
    for (n = 0; n < 60 && done !== 1'b1; n++) @(negedge clock);
    chk("done", 24'h000001, done);
    chk("busy", 24'h000000, busy);
  endtask
  task automatic t_place();
    pm.mem[15'h0100] = 24'h281234;
    pm.mem[15'h0101] = 24'h004321;
    run(OPC_LOAD_PLACE, 3'h0, 15'h0100, 6'h08);
    chk("flags", 24'h000031, flags_out);
    chk("inhibit", 24'h000001, no_interrupt);
    run(OPC_LOAD_PLACE, 3'h0, 15'h0101, 6'h34);
    chk("pc", 24'h001234, pc_seen);
    chk("flags", 24'h000015, flags_out);
  endtask
  task automatic t_restore();
    pm.mem[15'h0102] = 24'h500777;
    pm.mem[15'h0103] = 24'h280777;
    pm.mem[15'h0104] = 24'h000123;
    run(OPC_LOAD_RESTORE, 3'h0, 15'h0102, 6'h38);
    chk("pc", 24'h004321, pc_seen);
    chk("flags", 24'h000017, flags_out);
    run(OPC_LOAD_RESTORE, 3'h0, 15'h0103, 6'h06);
    chk("pc", 24'h000777, pc_seen);
    chk("flags", 24'h000031, flags_out);
    chk("inhibit", 24'h000001, no_interrupt);
    run(OPC_LOAD_RESTORE, 3'h0, 15'h0104, 6'h08);
    chk("pc", 24'h000777, pc_seen);
    chk("flags", 24'h000009, flags_out);
  endtask
  task automatic t_ldq();
    lat = 4'h3;
    pm.mem[15'h0200] = 24'hA5C3E1;
    run(OPC_LOAD_Q, 3'h0, 15'h0200, 6'h00);
    chk("q cell", 24'hA5C3E1, pm.mem[15'h0008]);
    chk("b reg", 24'hA5C3E1, b_reg);
    chk("source", 24'hA5C3E1, pm.mem[15'h0200]);
    chk("inhibit", 24'h000000, no_interrupt);
  endtask
  task automatic t_ldx();
    pm.mem[15'h0201] = 24'h3C5A96;
    run(OPC_LOAD_INDEX, 3'h5, 15'h0201, 6'h00);
    chk("index cell", 24'h3C5A96, pm.mem[15'h0005]);
    chk("inhibit", 24'h000001, no_interrupt);
    chk("illegal", 24'h000000, illegal);
    run(OPC_LOAD_INDEX, 3'h0, 15'h0201, 6'h00);
    chk("illegal", 24'h000001, illegal);
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      wrap_up();
    end
  end
  initial begin
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    t_place();
    t_restore();
    t_ldq();
    t_ldx();
    wrap_up();
  end
endmodule // ltexec_core_tb_top
`default_nettype wire
